// ### hw/spm_map.svh
// Address map, field positions, reset values and timing figures of the supply monitor
`ifndef SPM_MAP_SVH
`define SPM_MAP_SVH

`define SPM_CLK_PERIOD_NS   10
`define SPM_TICK_NS         250000
`define SPM_TICK_US         250

`define SPM_DLY_OC_US       8000
`define SPM_DLY_BAT_OV_US   32000
`define SPM_DLY_GND_OC_US   4000
`define SPM_DLY_GND_SC_US   250
`define SPM_DLY_TJ_US       256000
`define SPM_DLY_LOWBAT_US   256000

`define SPM_HI_LOW_MS       256
`define SPM_HI_PERIOD_MS    2560
`define SPM_LO_LOW_MS       128
`define SPM_LO_PERIOD_MS    1280

`define SPM_REG_CONV_STATUS 8'h33
`define SPM_REG_LOW_BATTERY 8'h34

`define SPM_ST_UVLO_BIT     4
`define SPM_ST_STARTED_BIT  5
`define SPM_ST_OV_BIT       6
`define SPM_ST_OC_BIT       7
`define SPM_LB_HIGH_BIT     0
`define SPM_LB_LOW_BIT      1
`define SPM_LB_MODE_BIT     2

`define SPM_LB_MODE_RST     1'h0
`define SPM_RDATA_RST       8'h00

`endif

// ### hw/spm_pkg.sv
// Types shared by the supply protection monitor
package spm_pkg;

    typedef enum logic [1:0] {
        SPM_V1P2 = 2'b00,
        SPM_V1P5 = 2'b01,
        SPM_V1P8 = 2'b10,
        SPM_V3P0 = 2'b11
    } spm_vout_t;

    typedef enum logic [1:0] {
        SPM_AL_IDLE     = 2'b00,
        SPM_AL_LEVEL    = 2'b01,
        SPM_AL_PULSE_HI = 2'b10,
        SPM_AL_PULSE_LO = 2'b11
    } spm_alert_t;

    typedef struct packed {
        logic vcc_below_stop;
        logic vcc_above_release;
        logic rail_above_start;
        logic rail_below_start;
        logic rail_above_ov;
        logic rail_below_ov;
        logic conv_overcurrent;
        logic bat_below_2v8;
        logic gnd_above_80mv;
        logic gnd_above_160mv;
        logic tj_above_68c;
        logic bat_below_lb_high;
        logic bat_below_lb_low;
    } spm_cmp_t;

    typedef struct packed {
        logic junction_hot;
        logic gnd_short;
        logic gnd_overcurrent;
        logic bat_overdischarge;
    } spm_prot_t;

endpackage

// ### hw/spm_debounce.sv
// Debounce timer counting timebase ticks of a continuous condition
`timescale 1ns/100ps
`default_nettype none

module spm_debounce #(
    parameter int TICKS = 16
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic tick,
    input  wire logic cond,
    output logic      detected
);
    // One extra tick: the first tick may come at once, so the delay never runs short
    localparam int LIMIT = TICKS + 1;
    localparam int CW    = $clog2(LIMIT + 1);
    localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);

    logic [CW-1:0] count;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            count <= '0;
        end else if (!cond) begin
            count <= '0;
        end else if (tick && count != LIMIT_C) begin
            count <= count + CW'(1);
        end
    end

    assign detected = cond && (count == LIMIT_C);

endmodule
`default_nettype wire

// ### hw/spm_monitor.sv
// Converter supervision, protection debounce and low-battery alert of the supply monitor
// What this block does
// - Select pins decode to 1.2/1.5/1.8/3.0 V.
// - Converter starts only with enable pin high.
// - Protection, junction heat or undervoltage stops converter.
// - Undervoltage status bit 4, thresholds follow voltage.
// - Start-up complete bit 5 with hysteresis.
// - Rail overvoltage halts switching, sets bit 6.
// - Overcurrent after 8 ms sets bit 7, factor.
// - Overcurrent interrupt needs role low, mask clear.
// - Battery under 2.8 V 32 ms: open discharge switch.
// - Ground sense over 80 mV 4 ms: resistor.
// - Ground sense over 160 mV 250 us: resistor.
// - Junction over 68 C 256 ms: suspend charging.
// - Released protection resumes everything automatically.
// - Suspension covers mode, irq, alert, serial pins.
// - Two low-battery levels, 256 ms debounce.
// - Level mode drives alert low while low.
// - Upper level pulses 256 ms per 2560 ms.
// - Lower level pulses 128 ms per 1280 ms.
// - Detection result kept in bits 1:0.
// - Serial slave reads registers with role low.
`timescale 1ns/100ps
`default_nettype none
`include "spm_map.svh"

module spm_monitor #(
    parameter int TICK_CYCLES = `SPM_TICK_NS / `SPM_CLK_PERIOD_NS
) (
    input  wire logic              clock,
    input  wire logic              rst_b,
    input  wire logic              converter_enable_pin,
    input  wire logic              output_select_bit0_pin,
    input  wire logic              output_select_bit1_pin,
    input  wire logic              role_select_pin,
    input  wire logic              oc_irq_mask,
    input  wire spm_pkg::spm_cmp_t cmp,
    input  wire logic [7:0]        reg_addr,
    input  wire logic              reg_read,
    input  wire logic              reg_write,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata,
    output logic                   reg_rvalid,
    output spm_pkg::spm_vout_t     target_voltage,
    output logic                   threshold_set_high,
    output logic                   converter_run,
    output logic                   converter_switch_en,
    output logic                   discharge_switch_on,
    output logic                   ground_resistor_connect,
    output logic                   charge_control_suspend,
    output logic                   digital_pins_suspend,
    output spm_pkg::spm_prot_t     protection,
    output logic                   irq_factor_overcurrent,
    output logic                   charge_irq_pin_o,
    output logic                   charge_irq_pin_oe,
    output logic                   low_battery_alert_pin_o,
    output logic                   low_battery_alert_pin_oe
);

    localparam int TW = $clog2(TICK_CYCLES);
    localparam int HI_LOW = `SPM_HI_LOW_MS * 1000 / `SPM_TICK_US;
    localparam int HI_PER = `SPM_HI_PERIOD_MS * 1000 / `SPM_TICK_US;
    localparam int LO_LOW = `SPM_LO_LOW_MS * 1000 / `SPM_TICK_US;
    localparam int LO_PER = `SPM_LO_PERIOD_MS * 1000 / `SPM_TICK_US;
    localparam int PW = $clog2(HI_PER);

    // Timebase tick, one cycle in every TICK_CYCLES
    logic [TW-1:0] tick_count;
    logic          tick;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            tick_count <= '0;
        end else if (tick) begin
            tick_count <= '0;
        end else begin
            tick_count <= tick_count + TW'(1);
        end
    end

    assign tick = (tick_count == TW'(TICK_CYCLES - 1));

    // Output voltage selection
    spm_pkg::spm_vout_t next_target;

    assign next_target = spm_pkg::spm_vout_t'({output_select_bit1_pin, output_select_bit0_pin});

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            target_voltage     <= spm_pkg::SPM_V1P2;
            threshold_set_high <= 1'b0;
        end else begin
            target_voltage     <= next_target;
            threshold_set_high <= (next_target == spm_pkg::SPM_V3P0);
        end
    end

    // Protection debounce
    logic det_oc;
    logic det_bat_ov;
    logic det_gnd_oc;
    logic det_gnd_sc;
    logic det_tj;
    logic det_lb_high;
    logic det_lb_low;

    spm_debounce #(.TICKS(`SPM_DLY_OC_US / `SPM_TICK_US)) u_db_oc (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.conv_overcurrent),
        .detected (det_oc)
    );

    spm_debounce #(.TICKS(`SPM_DLY_BAT_OV_US / `SPM_TICK_US)) u_db_bat (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.bat_below_2v8),
        .detected (det_bat_ov)
    );

    spm_debounce #(.TICKS(`SPM_DLY_GND_OC_US / `SPM_TICK_US)) u_db_goc (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.gnd_above_80mv),
        .detected (det_gnd_oc)
    );

    spm_debounce #(.TICKS(`SPM_DLY_GND_SC_US / `SPM_TICK_US)) u_db_gsc (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.gnd_above_160mv),
        .detected (det_gnd_sc)
    );

    spm_debounce #(.TICKS(`SPM_DLY_TJ_US / `SPM_TICK_US)) u_db_tj (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.tj_above_68c),
        .detected (det_tj)
    );

    spm_debounce #(.TICKS(`SPM_DLY_LOWBAT_US / `SPM_TICK_US)) u_db_lbh (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.bat_below_lb_high),
        .detected (det_lb_high)
    );

    spm_debounce #(.TICKS(`SPM_DLY_LOWBAT_US / `SPM_TICK_US)) u_db_lbl (
        .clock    (clock),
        .rst_b    (rst_b),
        .tick     (tick),
        .cond     (cmp.bat_below_lb_low),
        .detected (det_lb_low)
    );

    // Converter status flags, hysteresis held between the two comparator edges
    logic uvlo_ok;
    logic started;
    logic rail_ov;
    logic prot_any;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            uvlo_ok <= 1'b0;
            started <= 1'b0;
            rail_ov <= 1'b0;
        end else begin
            if (cmp.vcc_above_release) uvlo_ok <= 1'b1;
            else if (cmp.vcc_below_stop) uvlo_ok <= 1'b0;
            if (cmp.rail_above_start) started <= 1'b1;
            else if (cmp.rail_below_start) started <= 1'b0;
            if (cmp.rail_above_ov) rail_ov <= 1'b1;
            else if (cmp.rail_below_ov) rail_ov <= 1'b0;
        end
    end

    // Protection post-processing, released as soon as the condition goes
    spm_pkg::spm_prot_t next_prot;

    assign next_prot = '{junction_hot: det_tj, gnd_short: det_gnd_sc,
                         gnd_overcurrent: det_gnd_oc, bat_overdischarge: det_bat_ov};
    assign prot_any  = |protection;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            protection              <= '0;
            discharge_switch_on     <= 1'b0;
            ground_resistor_connect <= 1'b0;
            charge_control_suspend  <= 1'b0;
            digital_pins_suspend    <= 1'b0;
            irq_factor_overcurrent  <= 1'b0;
        end else begin
            protection              <= next_prot;
            discharge_switch_on     <= !(|next_prot);
            ground_resistor_connect <= det_gnd_oc || det_gnd_sc;
            charge_control_suspend  <= det_tj;
            digital_pins_suspend    <= |next_prot;
            irq_factor_overcurrent  <= det_oc;
        end
    end

    // Converter start and switching permission
    logic next_run;

    assign next_run = converter_enable_pin && uvlo_ok && !prot_any;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            converter_run       <= 1'b0;
            converter_switch_en <= 1'b0;
        end else begin
            converter_run       <= next_run;
            converter_switch_en <= next_run && !rail_ov;
        end
    end

    // Overcurrent interrupt, open drain
    assign charge_irq_pin_o = 1'b0;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            charge_irq_pin_oe <= 1'b0;
        end else begin
            charge_irq_pin_oe <= det_oc && !role_select_pin && !oc_irq_mask && !prot_any;
        end
    end

    // Register port; answers only as serial slave and while pins are not suspended
    logic alert_pulse_mode;
    logic reg_ok;

    assign reg_ok = !role_select_pin && !digital_pins_suspend;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alert_pulse_mode <= `SPM_LB_MODE_RST;
        end else if (reg_write && reg_ok && reg_addr == `SPM_REG_LOW_BATTERY) begin
            alert_pulse_mode <= reg_wdata[`SPM_LB_MODE_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= `SPM_RDATA_RST;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_read && reg_ok;
            if (reg_read && reg_ok) begin
                reg_rdata <= `SPM_RDATA_RST;
                if (reg_addr == `SPM_REG_CONV_STATUS) begin
                    reg_rdata[`SPM_ST_UVLO_BIT]    <= uvlo_ok;
                    reg_rdata[`SPM_ST_STARTED_BIT] <= started;
                    reg_rdata[`SPM_ST_OV_BIT]      <= rail_ov;
                    reg_rdata[`SPM_ST_OC_BIT]      <= det_oc;
                end else if (reg_addr == `SPM_REG_LOW_BATTERY) begin
                    reg_rdata[`SPM_LB_HIGH_BIT] <= det_lb_high;
                    reg_rdata[`SPM_LB_LOW_BIT]  <= det_lb_low;
                    reg_rdata[`SPM_LB_MODE_BIT] <= alert_pulse_mode;
                end
            end
        end
    end

    // Low-battery alert: level or pulse train, lower level wins
    spm_pkg::spm_alert_t alert_state;
    spm_pkg::spm_alert_t next_alert_state;
    logic [PW-1:0]       pulse_count;
    logic [PW-1:0]       next_pulse_count;
    logic [PW-1:0]       pulse_last;
    logic                next_alert_oe;

    always_comb begin
        if (digital_pins_suspend || !(det_lb_high || det_lb_low)) begin
            next_alert_state = spm_pkg::SPM_AL_IDLE;
        end else if (!alert_pulse_mode) begin
            next_alert_state = spm_pkg::SPM_AL_LEVEL;
        end else if (det_lb_low) begin
            next_alert_state = spm_pkg::SPM_AL_PULSE_LO;
        end else begin
            next_alert_state = spm_pkg::SPM_AL_PULSE_HI;
        end
    end

    assign pulse_last = (next_alert_state == spm_pkg::SPM_AL_PULSE_LO) ? PW'(LO_PER - 1) : PW'(HI_PER - 1);

    always_comb begin
        if (next_alert_state != alert_state) begin
            next_pulse_count = '0;
        end else if (tick) begin
            next_pulse_count = (pulse_count == pulse_last) ? '0 : pulse_count + PW'(1);
        end else begin
            next_pulse_count = pulse_count;
        end
    end

    always_comb begin
        unique case (next_alert_state)
            spm_pkg::SPM_AL_IDLE:     next_alert_oe = 1'b0;
            spm_pkg::SPM_AL_LEVEL:    next_alert_oe = 1'b1;
            spm_pkg::SPM_AL_PULSE_HI: next_alert_oe = next_pulse_count < PW'(HI_LOW);
            spm_pkg::SPM_AL_PULSE_LO: next_alert_oe = next_pulse_count < PW'(LO_LOW);
        endcase
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            alert_state              <= spm_pkg::SPM_AL_IDLE;
            pulse_count              <= '0;
            low_battery_alert_pin_oe <= 1'b0;
        end else begin
            alert_state              <= next_alert_state;
            pulse_count              <= next_pulse_count;
            low_battery_alert_pin_oe <= next_alert_oe;
        end
    end

    assign low_battery_alert_pin_o = 1'b0;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_enter_hi;
        (alert_state != spm_pkg::SPM_AL_PULSE_HI) ##1 (alert_state == spm_pkg::SPM_AL_PULSE_HI);
    endsequence

    sequence s_enter_lo;
        (alert_state != spm_pkg::SPM_AL_PULSE_LO) ##1 (alert_state == spm_pkg::SPM_AL_PULSE_LO);
    endsequence

    a_target_decode: assert property (
        target_voltage == spm_pkg::spm_vout_t'({$past(output_select_bit1_pin), $past(output_select_bit0_pin)}))
        else $error("target voltage does not follow select pins");
    a_start_enable: assert property ($rose(converter_run) |-> $past(converter_enable_pin))
        else $error("converter started without enable");
    a_stop_fault: assert property ((prot_any || !uvlo_ok) |=> !converter_run)
        else $error("converter runs during fault");
    a_uvlo_stop: assert property (cmp.vcc_below_stop && !cmp.vcc_above_release |=> !uvlo_ok)
        else $error("undervoltage flag not cleared");
    a_start_flag: assert property (cmp.rail_above_start |=> started)
        else $error("start-up flag not set");
    a_ov_halt: assert property (rail_ov |=> !converter_switch_en)
        else $error("switching during overvoltage");
    a_oc_irq: assert property ($rose(charge_irq_pin_oe) |-> !$past(role_select_pin) && !$past(oc_irq_mask) && $past(det_oc))
        else $error("overcurrent interrupt without role or mask");
    a_prot_switch: assert property ((|next_prot) |=> !discharge_switch_on && digital_pins_suspend)
        else $error("discharge switch on during protection");
    a_gnd_resistor: assert property ((det_gnd_oc || det_gnd_sc) |=> ground_resistor_connect)
        else $error("ground resistor not connected");
    a_level_alert: assert property ((alert_state == spm_pkg::SPM_AL_LEVEL) |-> low_battery_alert_pin_oe)
        else $error("level alert not driven");
    a_pulse_start: assert property ((s_enter_hi or s_enter_lo) |-> low_battery_alert_pin_oe)
        else $error("pulse train does not start low");
    a_lb_status: assert property (reg_read && reg_ok && reg_addr == `SPM_REG_LOW_BATTERY |=>
        reg_rvalid && reg_rdata[`SPM_LB_LOW_BIT] == $past(det_lb_low))
        else $error("low-battery status mismatch");

endmodule
`default_nettype wire

// ### bench/spm_app_model.sv
// Application-side model: pulled-up open-drain alert and interrupt lines
`timescale 1ns/100ps
`default_nettype none

module spm_app_model (
    input  wire logic alert_oe,
    input  wire logic irq_oe,
    output logic      alert_level,
    output logic      irq_level
);
    // Board pull-ups: a released line reads high, never a stale value
    assign alert_level = alert_oe ? 1'b0 : 1'b1;
    assign irq_level   = irq_oe ? 1'b0 : 1'b1;
endmodule

`default_nettype wire

// ### bench/supply_protection_monitor_bench.sv
// Self-checking bench of the supply protection monitor
`timescale 1ns/100ps
`default_nettype none

module supply_protection_monitor_bench;
    // Short tick keeps the 2560 ms pulse period affordable in cycles
    localparam int TC = 2;
    logic               clock, rst_b, converter_enable_pin, role_select_pin, oc_irq_mask;
    logic               output_select_bit0_pin, output_select_bit1_pin, reg_read, reg_write;
    logic [7:0]         reg_addr, reg_wdata, reg_rdata;
    spm_pkg::spm_cmp_t  cmp;
    spm_pkg::spm_vout_t target_voltage;
    spm_pkg::spm_prot_t protection;
    logic               threshold_set_high, converter_run, converter_switch_en, reg_rvalid;
    logic               discharge_switch_on, ground_resistor_connect, charge_control_suspend;
    logic               digital_pins_suspend, irq_factor_overcurrent, charge_irq_pin_oe;
    logic               low_battery_alert_pin_oe, alert_level, irq_level;
    logic [5:0]         flags;
    int                 tk[4] = '{128, 16, 1, 1024};
    int                 num_errors = 0;
    int                 cmp_count = 0;

    assign flags = {low_battery_alert_pin_oe, irq_factor_overcurrent, protection};

    spm_monitor #(.TICK_CYCLES(TC)) spm_monitor_i (
        .clock, .rst_b, .converter_enable_pin, .output_select_bit0_pin, .output_select_bit1_pin,
        .role_select_pin, .oc_irq_mask, .cmp, .reg_addr, .reg_read, .reg_write, .reg_wdata,
        .reg_rdata, .reg_rvalid, .target_voltage, .threshold_set_high, .converter_run,
        .converter_switch_en, .discharge_switch_on, .ground_resistor_connect,
        .charge_control_suspend, .digital_pins_suspend, .protection, .irq_factor_overcurrent,
        .charge_irq_pin_o(), .charge_irq_pin_oe, .low_battery_alert_pin_o(),
        .low_battery_alert_pin_oe
    );

    spm_app_model spm_app_model_i (
        .alert_oe(low_battery_alert_pin_oe), .irq_oe(charge_irq_pin_oe),
        .alert_level(alert_level), .irq_level(irq_level)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // Durations get two cycles of slack for tick phase
    task automatic chk_len(input int got, input int exp, input string what);
        cmp_count++;
        if (got < exp - 2 || got > exp + 2) begin
            num_errors++;
            $display("[ERR] %0t %s length %0d expected %0d", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp, input logic ok);
        reg_addr = a;
        reg_read = 1'b1;
        cyc(1);
        reg_read = 1'b0;
        chk(reg_rvalid, ok, "rvalid");
        if (ok) chk(reg_rdata, exp, "rdata");
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        cyc(1);
        reg_write = 1'b0;
    endtask

    task automatic wait_oe(input logic v);
        int n = 0;
        while (low_battery_alert_pin_oe !== v && n < 12000) begin
            cyc(1);
            n++;
        end
        chk(low_battery_alert_pin_oe, v, "alert wait");
    endtask

    // Flag must stay clear until the delay, then rise within three ticks and four cycles
    task automatic dly(input int s, input int ticks);
        int n = 0;
        cyc(ticks * TC - 1);
        chk(flags[s], 1'b0, "early");
        while (flags[s] !== 1'b1 && n < 3 * TC + 4) begin
            cyc(1);
            n++;
        end
        chk(flags[s], 1'b1, "late");
    endtask

    task automatic pulse(input int lo, input int per);
        int a = 0;
        int b = 0;
        while (low_battery_alert_pin_oe === 1'b1 && a < 30000) begin
            cyc(1);
            a++;
        end
        while (low_battery_alert_pin_oe === 1'b0 && b < 30000) begin
            cyc(1);
            b++;
        end
        chk_len(a, lo * TC, "low phase");
        chk_len(a + b, per * TC, "period");
    endtask

    task automatic set_prot(input int k, input logic v);
        case (k)
            0: cmp.bat_below_2v8 = v;
            1: cmp.gnd_above_80mv = v;
            2: cmp.gnd_above_160mv = v;
            default: cmp.tj_above_68c = v;
        endcase
    endtask

    initial begin
        #800000;
        num_errors++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        // Enable high and serial slave role from the start
        {rst_b, converter_enable_pin, role_select_pin, oc_irq_mask, reg_read, reg_write} = 6'h10;
        {output_select_bit1_pin, output_select_bit0_pin} = 2'b00;
        {reg_addr, reg_wdata} = 16'h0000;
        cmp = '0;
        cyc(4);
        chk(reg_rdata, 8'h00, "reset data");
        chk({converter_run, discharge_switch_on}, 2'b00, "reset outputs");
        rst_b = 1'b1;
        cyc(1);
        for (int v = 0; v < 4; v++) begin
            {output_select_bit1_pin, output_select_bit0_pin} = v[1:0];
            cyc(2);
            chk(target_voltage, v[1:0], "vout");
            chk(threshold_set_high, v == 3, "thresholds");
        end
        {output_select_bit1_pin, output_select_bit0_pin} = 2'b00;
        $display("Test decode finished");

        cmp.vcc_above_release = 1'b1;
        cyc(3);
        chk(converter_run, 1'b1, "run");
        rd_reg(8'h33, 8'h10, 1'b1);
        converter_enable_pin = 1'b0;
        cyc(3);
        chk(converter_run, 1'b0, "enable low");
        converter_enable_pin = 1'b1;
        cmp.vcc_above_release = 1'b0;
        cmp.vcc_below_stop = 1'b1;
        cyc(1);
        cmp.vcc_below_stop = 1'b0;
        cyc(3);
        chk(converter_run, 1'b0, "uvlo");
        rd_reg(8'h33, 8'h00, 1'b1);
        cmp.vcc_above_release = 1'b1;
        cmp.rail_above_start = 1'b1;
        cyc(1);
        cmp.rail_above_start = 1'b0;
        cyc(3);
        rd_reg(8'h33, 8'h30, 1'b1);
        cmp.rail_above_ov = 1'b1;
        cyc(1);
        cmp.rail_above_ov = 1'b0;
        cyc(2);
        chk({converter_run, converter_switch_en}, 2'b10, "ov");
        rd_reg(8'h33, 8'h70, 1'b1);
        cmp.rail_below_ov = 1'b1;
        cmp.rail_below_start = 1'b1;
        cyc(1);
        {cmp.rail_below_ov, cmp.rail_below_start} = 2'b00;
        cyc(2);
        chk(converter_switch_en, 1'b1, "ov clear");
        rd_reg(8'h33, 8'h10, 1'b1);
        $display("Test converter finished");

        cmp.conv_overcurrent = 1'b1;
        cyc(20 * TC);
        cmp.conv_overcurrent = 1'b0;
        cyc(1);
        cmp.conv_overcurrent = 1'b1;
        dly(4, 32);
        cyc(1);
        chk(irq_level, 1'b0, "irq");
        rd_reg(8'h33, 8'h90, 1'b1);
        oc_irq_mask = 1'b1;
        cyc(2);
        chk(charge_irq_pin_oe, 1'b0, "masked");
        {oc_irq_mask, role_select_pin} = 2'b01;
        cyc(2);
        chk(charge_irq_pin_oe, 1'b0, "role high");
        rd_reg(8'h33, 8'h00, 1'b0);
        {role_select_pin, cmp.conv_overcurrent} = 2'b00;
        cyc(3);
        chk(irq_factor_overcurrent, 1'b0, "oc clear");
        $display("Test overcurrent finished");

        for (int k = 0; k < 4; k++) begin
            set_prot(k, 1'b1);
            dly(k, tk[k]);
            cyc(2);
            chk({converter_run, discharge_switch_on, ground_resistor_connect, charge_control_suspend,
                 digital_pins_suspend}, {2'b00, k == 1 || k == 2, k == 3, 1'b1}, "post");
            rd_reg(8'h33, 8'h00, 1'b0);
            set_prot(k, 1'b0);
            cyc(3);
            chk({converter_run, discharge_switch_on, ground_resistor_connect, charge_control_suspend,
                 digital_pins_suspend}, 5'h18, "resume");
        end
        $display("Test protection finished");

        rd_reg(8'h50, 8'h00, 1'b1);
        wr_reg(8'h33, 8'hff);
        rd_reg(8'h33, 8'h10, 1'b1);
        wr_reg(8'h34, 8'hff);
        rd_reg(8'h34, 8'h04, 1'b1);
        wr_reg(8'h34, 8'h00);
        $display("Test registers finished");

        cmp.bat_below_lb_high = 1'b1;
        dly(5, 1024);
        chk(alert_level, 1'b0, "alert low");
        rd_reg(8'h34, 8'h01, 1'b1);
        cmp.bat_below_lb_high = 1'b0;
        cyc(3);
        chk(alert_level, 1'b1, "alert released");
        wr_reg(8'h34, 8'h04);
        cmp.bat_below_lb_high = 1'b1;
        dly(5, 1024);
        pulse(1024, 10240);
        rd_reg(8'h34, 8'h05, 1'b1);
        cmp.bat_below_lb_low = 1'b1;
        cyc(1030 * TC);
        wait_oe(1'b0);
        wait_oe(1'b1);
        pulse(512, 5120);
        rd_reg(8'h34, 8'h07, 1'b1);
        {cmp.bat_below_lb_high, cmp.bat_below_lb_low} = 2'b00;
        cyc(3);
        chk(low_battery_alert_pin_oe, 1'b0, "alert idle");
        $display("Test low battery finished");
        conclude();
    end
endmodule

`default_nettype wire
